// ===== logic/lfx_defines.svh
`ifndef LFX_DEFINES_SVH
`define LFX_DEFINES_SVH
`define LFX_OFF_SUBSYS_VENDOR 8'h2c
`define LFX_OFF_SUBSYS_ID 8'h2e
`define LFX_OFF_PM_BRIDGE_EXT 8'h4a
`define LFX_OFF_PM_DATA 8'h4b
`define LFX_OFF_MISC_CTRL 8'h50
`define LFX_OFF_SUBSYS_ACCESS 8'hf8
`define LFX_RST_PM_BRIDGE_EXT 8'h00
`define LFX_RST_PM_DATA 8'h00
`define LFX_RST_MISC_CTRL 8'h00
`define LFX_RST_SUBSYS_ACCESS 32'h0000_0000
`define LFX_POS_REV23 0
`define LFX_POS_INT_DISABLE 10
`define LFX_POS_INT_STATUS 3
`endif

// ===== logic/lfx_pkg.sv
package lfx_pkg;
    typedef logic [7:0] lfx_byte_t;
    typedef logic [31:0] lfx_dword_t;
    typedef logic [3:0] lfx_be_t;
endpackage

// ===== logic/lfx_subsys_store.sv
`timescale 1ns/1ps
`include "lfx_defines.svh"
module lfx_subsys_store (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Write side
    input wire logic wr_en,
    input wire lfx_pkg::lfx_be_t wr_be,
    input wire lfx_pkg::lfx_dword_t wr_data,
    // Held word
    output lfx_pkg::lfx_dword_t held
);
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_lane
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    held[8*i +: 8] <= 8'h00;
                end else if (wr_en && wr_be[i]) begin
                    held[8*i +: 8] <= wr_data[8*i +: 8];
                end
            end
        end
    endgenerate
endmodule

// ===== logic/lfx_cfg_extras.sv
`timescale 1ns/1ps
`include "lfx_defines.svh"
module lfx_cfg_extras (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Configuration access, dword addressed with byte enables
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire lfx_pkg::lfx_be_t cfg_be,
    input wire lfx_pkg::lfx_dword_t cfg_wdata,
    output lfx_pkg::lfx_dword_t cfg_rdata,
    output logic cfg_hit,
    // Interrupt bits of the command and status registers
    input wire logic int_disable_raw,
    input wire logic int_pending,
    output logic int_disable_eff,
    output logic int_status_eff,
    output logic int_request,
    // Mode and alias views
    output logic rev23_conformance_select,
    output logic [15:0] subsys_product_code,
    output logic [15:0] subsys_maker_code
);
    lfx_pkg::lfx_dword_t subsys_held;
    lfx_pkg::lfx_dword_t next_rdata;
    logic misc_mode_control;
    // Byte offsets in one dword share a decode; low address bits are ignored
    function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] offset);
        return addr[7:2] == offset[7:2];
    endfunction

    wire sel_pm = dword_hit(cfg_addr, `LFX_OFF_PM_BRIDGE_EXT);
    wire sel_misc = dword_hit(cfg_addr, `LFX_OFF_MISC_CTRL);
    wire sel_acc = dword_hit(cfg_addr, `LFX_OFF_SUBSYS_ACCESS);
    wire sel_alias = dword_hit(cfg_addr, `LFX_OFF_SUBSYS_VENDOR);
    wire wr_misc = cfg_wr && sel_misc && cfg_be[0];
    wire wr_acc = cfg_wr && sel_acc;
    wire rd_pm = cfg_rd && sel_pm;
    wire rd_misc = cfg_rd && sel_misc;
    wire rd_acc = cfg_rd && sel_acc;
    wire rd_alias = cfg_rd && sel_alias;
    wire [7:0] misc_view = {7'h00, misc_mode_control};
    // The PM word at 48h holds control/status owned elsewhere; only upper bytes are ours
    wire [31:0] pm_word = {`LFX_RST_PM_DATA, `LFX_RST_PM_BRIDGE_EXT, 16'h0000};
    assign cfg_hit = sel_pm || sel_misc || sel_acc || sel_alias;
    assign next_rdata = sel_pm ? pm_word :
                        sel_misc ? {24'h000000, misc_view} :
                        (sel_acc || sel_alias) ? subsys_held :
                        32'h0000_0000;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            misc_mode_control <= 1'b0;
        end else if (wr_misc) begin
            misc_mode_control <= cfg_wdata[`LFX_POS_REV23];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (cfg_rd) begin
            cfg_rdata <= next_rdata;
        end
    end

    lfx_subsys_store u_store (
        .mclk(mclk),
        .rstn(rstn),
        .wr_en(wr_acc),
        .wr_be(cfg_be),
        .wr_data(cfg_wdata),
        .held(subsys_held)
    );

    // Alias registers are read-only; only F8h writes reach the store
    assign subsys_product_code = subsys_held[31:16];
    assign subsys_maker_code = subsys_held[15:0];
    assign rev23_conformance_select = misc_mode_control;
    // In 2.2 mode the disable bit is ignored so legacy drivers keep interrupts
    assign int_disable_eff = misc_mode_control & int_disable_raw;
    assign int_status_eff = misc_mode_control & int_pending;
    assign int_request = int_pending & ~int_disable_eff;

    a_pm_reads_zero: assert property (@(posedge mclk) disable iff (!rstn)
        rd_pm |=> cfg_rdata[31:16] == 16'h0000)
        else $error("pm bytes not zero");
    a_pm_ext_zero: assert property (@(posedge mclk) disable iff (!rstn)
        rd_pm |=> cfg_rdata[23:16] == `LFX_RST_PM_BRIDGE_EXT)
        else $error("pm bridge extension byte not zero");
    a_pm_data_zero: assert property (@(posedge mclk) disable iff (!rstn)
        rd_pm |=> cfg_rdata[31:24] == `LFX_RST_PM_DATA)
        else $error("pm data byte not zero");
    a_pm_write_inert: assert property (@(posedge mclk) disable iff (!rstn)
        cfg_wr && sel_pm |=> $stable(rev23_conformance_select) && $stable(subsys_held))
        else $error("pm write changed state");

    a_misc_mode_set: assert property (@(posedge mclk) disable iff (!rstn)
        wr_misc |=> rev23_conformance_select == $past(cfg_wdata[0]))
        else $error("mode bit not written");
    a_misc_set: assert property (@(posedge mclk) disable iff (!rstn)
        wr_misc && cfg_wdata[0] |=> rev23_conformance_select)
        else $error("mode bit not set");
    a_misc_clear: assert property (@(posedge mclk) disable iff (!rstn)
        wr_misc && !cfg_wdata[0] |=> !rev23_conformance_select)
        else $error("mode bit not cleared");
    a_misc_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !wr_misc |=> $stable(rev23_conformance_select))
        else $error("mode bit changed without write");
    // A write without lane 0 enabled must leave the mode alone
    a_misc_be_gate: assert property (@(posedge mclk) disable iff (!rstn)
        cfg_wr && sel_misc && !cfg_be[0] |=> $stable(rev23_conformance_select))
        else $error("mode bit written without lane 0");
    a_misc_readback: assert property (@(posedge mclk) disable iff (!rstn)
        rd_misc |=> cfg_rdata[0] == $past(rev23_conformance_select))
        else $error("mode bit readback wrong");
    a_misc_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
        rd_misc |=> cfg_rdata[31:1] == 31'h0)
        else $error("reserved misc bits set");
    a_misc_upper_zero: assert property (@(posedge mclk) disable iff (!rstn)
        rd_misc |=> cfg_rdata[7:1] == 7'h00)
        else $error("misc bits 7 to 1 set");

    a_rev22_masks_int: assert property (@(posedge mclk) disable iff (!rstn)
        !rev23_conformance_select |-> !int_status_eff && !int_disable_eff)
        else $error("2.3 bits active in 2.2 mode");
    a_rev23_int_live: assert property (@(posedge mclk) disable iff (!rstn)
        rev23_conformance_select && int_pending |-> int_status_eff
        && (int_request == !int_disable_raw))
        else $error("2.3 interrupt bits not functional");
    a_int_dis_pass: assert property (@(posedge mclk) disable iff (!rstn)
        rev23_conformance_select |-> int_disable_eff == int_disable_raw)
        else $error("disable bit not passed in 2.3 mode");
    a_int_stat_pass: assert property (@(posedge mclk) disable iff (!rstn)
        rev23_conformance_select |-> int_status_eff == int_pending)
        else $error("status bit not passed in 2.3 mode");
    a_int_req_gated: assert property (@(posedge mclk) disable iff (!rstn)
        rev23_conformance_select |-> int_request == (int_pending && !int_disable_raw))
        else $error("request not gated in 2.3 mode");
    a_int_req_legacy: assert property (@(posedge mclk) disable iff (!rstn)
        !rev23_conformance_select |-> int_request == int_pending)
        else $error("request gated in 2.2 mode");
    a_int_req_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        !int_pending |-> !int_request && !int_status_eff)
        else $error("interrupt shown without cause");

    // Checked on the first edge after release, before any access can land
    a_reset_mode_clear: assert property (@(posedge mclk)
        $rose(rstn) |-> !rev23_conformance_select)
        else $error("mode bit set after reset");
    a_reset_acc_zero: assert property (@(posedge mclk)
        $rose(rstn) |-> subsys_held == `LFX_RST_SUBSYS_ACCESS)
        else $error("access register not zero after reset");
    a_reset_codes_zero: assert property (@(posedge mclk)
        $rose(rstn) |-> subsys_product_code == 16'h0000 && subsys_maker_code == 16'h0000)
        else $error("alias codes not zero after reset");

    // A partial write must leave the other lanes of the alias untouched
    a_alias_upper: assert property (@(posedge mclk) disable iff (!rstn)
        wr_acc && (&cfg_be) |=> subsys_product_code == $past(cfg_wdata[31:16]))
        else $error("product code alias wrong");
    a_alias_lower: assert property (@(posedge mclk) disable iff (!rstn)
        wr_acc && (&cfg_be) |=> subsys_maker_code == $past(cfg_wdata[15:0]))
        else $error("maker code alias wrong");
    a_lane0_write: assert property (@(posedge mclk) disable iff (!rstn)
        wr_acc && cfg_be[0] |=> subsys_maker_code[7:0] == $past(cfg_wdata[7:0]))
        else $error("lane 0 not written");
    a_lane1_write: assert property (@(posedge mclk) disable iff (!rstn)
        wr_acc && cfg_be[1] |=> subsys_maker_code[15:8] == $past(cfg_wdata[15:8]))
        else $error("lane 1 not written");
    a_lane2_write: assert property (@(posedge mclk) disable iff (!rstn)
        wr_acc && cfg_be[2] |=> subsys_product_code[7:0] == $past(cfg_wdata[23:16]))
        else $error("lane 2 not written");
    a_lane3_write: assert property (@(posedge mclk) disable iff (!rstn)
        wr_acc && cfg_be[3] |=> subsys_product_code[15:8] == $past(cfg_wdata[31:24]))
        else $error("lane 3 not written");
    a_lane0_keep: assert property (@(posedge mclk) disable iff (!rstn)
        !(wr_acc && cfg_be[0]) |=> $stable(subsys_maker_code[7:0]))
        else $error("lane 0 changed without write");
    a_lane1_keep: assert property (@(posedge mclk) disable iff (!rstn)
        !(wr_acc && cfg_be[1]) |=> $stable(subsys_maker_code[15:8]))
        else $error("lane 1 changed without write");
    a_lane2_keep: assert property (@(posedge mclk) disable iff (!rstn)
        !(wr_acc && cfg_be[2]) |=> $stable(subsys_product_code[7:0]))
        else $error("lane 2 changed without write");
    a_lane3_keep: assert property (@(posedge mclk) disable iff (!rstn)
        !(wr_acc && cfg_be[3]) |=> $stable(subsys_product_code[15:8]))
        else $error("lane 3 changed without write");
    a_alias_write_inert: assert property (@(posedge mclk) disable iff (!rstn)
        cfg_wr && sel_alias |=> $stable(subsys_held))
        else $error("alias dword accepted a write");

    // Read data is registered, so it shows what was held one cycle earlier
    a_acc_readback: assert property (@(posedge mclk) disable iff (!rstn)
        rd_acc |=> cfg_rdata == $past({subsys_product_code, subsys_maker_code}))
        else $error("access readback mismatch");
    a_acc_hi_readback: assert property (@(posedge mclk) disable iff (!rstn)
        rd_acc |=> cfg_rdata[31:16] == $past(subsys_product_code))
        else $error("access upper half readback wrong");
    a_acc_lo_readback: assert property (@(posedge mclk) disable iff (!rstn)
        rd_acc |=> cfg_rdata[15:0] == $past(subsys_maker_code))
        else $error("access lower half readback wrong");
    a_alias_readback: assert property (@(posedge mclk) disable iff (!rstn)
        rd_alias |=> cfg_rdata == $past(subsys_held))
        else $error("alias dword readback wrong");
    a_rdata_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !cfg_rd |=> $stable(cfg_rdata))
        else $error("read data changed without read");
    a_read_keeps_store: assert property (@(posedge mclk) disable iff (!rstn)
        cfg_rd && !cfg_wr |=> $stable(subsys_held))
        else $error("read changed the access register");
endmodule

// ===== verif/lfx_host_model.sv
`timescale 1ns/1ps
module lfx_host_model (
    // Clock
    input wire logic mclk,
    // Configuration cycles
    output logic cfg_rd,
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    output lfx_pkg::lfx_be_t cfg_be,
    output lfx_pkg::lfx_dword_t cfg_wdata,
    input wire lfx_pkg::lfx_dword_t cfg_rdata,
    input wire logic cfg_hit
);
    initial begin
        {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
    end
    // Released lines show the inverse, so a stale value never passes
    task automatic wr(input logic [7:0] a, input lfx_pkg::lfx_be_t b, input lfx_pkg::lfx_dword_t d);
        @(posedge mclk) #1;
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, b, d};
        @(posedge mclk) #1;
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b0, ~a, ~b, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output lfx_pkg::lfx_dword_t d);
        @(posedge mclk) #1;
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(posedge mclk) #1;
        {cfg_rd, cfg_addr} = {1'b0, ~a};
        d = cfg_rdata;
    endtask
    // Address only, no strobe: the decode flag is combinational on the address
    task automatic probe(input logic [7:0] a, output logic h);
        @(posedge mclk) #1;
        cfg_addr = a;
        #1;
        h = cfg_hit;
        @(posedge mclk) #1;
        cfg_addr = ~a;
    endtask
endmodule

// ===== verif/lfx_cfg_extras_tb_top.sv
`timescale 1ns/1ps
module lfx_cfg_extras_tb_top;
    logic mclk, rstn, irq_dis, irq_pend, cfg_rd, cfg_wr, ide, ise, ireq, mode, hit, h;
    logic [7:0] cfg_addr;
    logic [15:0] prod, mkr;
    lfx_pkg::lfx_be_t cfg_be;
    lfx_pkg::lfx_dword_t cfg_wdata, cfg_rdata, v;
    int miscompares = 0;
    int checks_done = 0;
    lfx_host_model host (.mclk(mclk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(hit));
    lfx_cfg_extras dut (.mclk(mclk), .rstn(rstn), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_hit(hit), .int_disable_raw(irq_dis), .int_pending(irq_pend), .int_disable_eff(ide),
        .int_status_eff(ise), .int_request(ireq), .rev23_conformance_select(mode),
        .subsys_product_code(prod), .subsys_maker_code(mkr));
    task automatic chk(input lfx_pkg::lfx_dword_t seen, input lfx_pkg::lfx_dword_t exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    // Whole run is under two hundred cycles; this allows ten times that
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
    initial begin
        {rstn, irq_dis, irq_pend} = 3'b011;
        repeat (8) @(posedge mclk);
        #1 rstn = 1;
        host.rd(8'h48, v);
        chk(v, 32'h0);
        host.rd(8'h4b, v);
        chk(v, 32'h0);
        host.rd(8'h50, v);
        chk(v, 32'h0);
        host.rd(8'hf8, v);
        chk(v, 32'h0);
        chk(32'({mode, ide, ise, ireq}), 32'h1);
        $display("reset test done");
        host.probe(8'h4a, h);
        chk(32'(h), 32'h1);
        host.probe(8'h53, h);
        chk(32'(h), 32'h1);
        host.probe(8'h2e, h);
        chk(32'(h), 32'h1);
        host.probe(8'hfc, h);
        chk(32'(h), 32'h0);
        $display("decode test done");
        host.wr(8'h48, 4'hf, 32'hffff_ffff);
        host.rd(8'h48, v);
        chk(v, 32'h0);
        host.wr(8'h50, 4'h1, 32'h0000_00ff);
        host.rd(8'h50, v);
        chk(v, 32'h1);
        chk(32'({mode, ide, ise, ireq}), 32'he);
        @(posedge mclk) #1 irq_dis = 0;
        @(posedge mclk) #1 chk(32'({mode, ide, ise, ireq}), 32'hb);
        @(posedge mclk) #1 irq_pend = 0;
        @(posedge mclk) #1 chk(32'({mode, ide, ise, ireq}), 32'h8);
        host.wr(8'h50, 4'he, 32'h0000_0000);
        host.rd(8'h50, v);
        chk(v, 32'h1);
        @(posedge mclk) #1 {irq_dis, irq_pend} = 2'b11;
        host.wr(8'h50, 4'h1, 32'h0000_0000);
        chk(32'({mode, ide, ise, ireq}), 32'h1);
        $display("mode test done");
        host.wr(8'hf8, 4'hf, 32'h1234_abcd);
        chk({prod, mkr}, 32'h1234_abcd);
        host.wr(8'hf8, 4'h3, 32'hffff_5555);
        chk({prod, mkr}, 32'h1234_5555);
        host.wr(8'hf8, 4'hc, 32'h5678_0000);
        chk({prod, mkr}, 32'h5678_5555);
        host.wr(8'h2c, 4'hf, 32'hffff_ffff);
        host.rd(8'h2e, v);
        chk(v, 32'h5678_5555);
        host.rd(8'hf8, v);
        chk(v, 32'h5678_5555);
        host.rd(8'h00, v);
        chk(v, 32'h0);
        $display("alias test done");
        host.wr(8'h50, 4'h1, 32'h0000_0001);
        @(posedge mclk) #1 rstn = 0;
        repeat (2) @(posedge mclk);
        #1 rstn = 1;
        chk(32'(mode), 32'h0);
        chk({prod, mkr}, 32'h0);
        host.rd(8'h50, v);
        chk(v, 32'h0);
        host.rd(8'hf8, v);
        chk(v, 32'h0);
        $display("second reset test done");
        test_done();
    end
endmodule
